// ==== logic/dpm_monitors.sv ====
// drive protection monitors: voltage, speed, current and temperature comparators
// Operation
// - flag undervoltage below selected off threshold
// - clear undervoltage above off threshold again
// - pulse inhibit at undervoltage threshold
// - one mains selection for both voltage monitors
// - log undervoltage over 3 s or mains
// - mains return deletes pending, no log
// - short undervoltage logged as interference
// - undervoltage fixed message, fault 1030
// - overspeed trip on magnitude, fault 200
// - overspeed also above twice max speed
// - phase short or earth at mains, fault 11
// - earth fault trip, fault 12
// - heatsink fixed comparator with hysteresis, fault 50
// - motor fixed comparator 150 with 15 K
// - motor fixed reaction trip or off, 53
// - motor fixed monitor enabled by default
// - heatsink warning adjustable with 5 K
// - both warnings warning or off, 2054/2057
// - motor warning adjustable, 15 K hysteresis
// - selection table 285/328/342 volt thresholds
module dpm_monitors
    import dpm_pkg::*;
#(
    parameter longint UV_PERSIST = UV_PERSIST_CYC // cycles of undervoltage before long entry
) (
    input  wire logic        clk,                  // 20 MHz system clock
    input  wire logic        rst_n,                // synchronous reset, active low
    input  wire logic        sample_en,            // one-cycle sampling strobe
    input  wire logic [9:0]  dc_bus_voltage,       // dc bus in volts
    input  wire logic [15:0] actual_speed,         // signed speed
    input  wire logic [7:0]  heatsink_temperature, // heatsink degrees C
    input  wire logic [7:0]  motor_temperature,    // motor degrees C
    input  wire logic        phase_short_in,       // raw short-circuit comparator pin
    input  wire logic        earth_in,             // raw earth-fault pin
    input  wire logic        mains_on_in,          // raw mains-present pin
    input  wire logic [3:0]  reg_addr,             // register index
    input  wire logic [15:0] reg_wdata,            // write data
    input  wire logic        reg_wr,               // write strobe
    input  wire logic        reg_rd,               // read strobe
    output logic      [15:0] reg_rdata,            // read data, cycle after strobe
    output logic             undervoltage_flag,    // message flag
    output logic             overvoltage_flag,     // message flag
    output logic             pulse_inhibit,        // power stage inhibit
    output logic             trip,                 // any trip-reaction monitor active
    output logic             warning,              // any warning active
    output logic             hist_wr,              // one-cycle history write pulse
    output logic      [11:0] hist_fault_num        // fault number with hist_wr
);
    // configuration and flags
    logic [2:0]  ctrl_ff;
    logic [2:0]  mains_sel_ff;
    logic [15:0] max_speed_ff;
    logic [7:0]  hs_thr_ff;
    logic [7:0]  mot_thr_ff;
    logic        uv_ff, ov_ff, inh_ff, ospd_ff, short_ff, earth_ff;
    logic        hsfix_ff, mtfix_ff, hsw_ff, mtw_ff, uv_pend_ff;
    logic [15:0] hist_cnt_ff;
    logic [11:0] hist_num_ff;
    logic        hist_wr_ff;
    logic [15:0] rdata_ff;
    logic        trip_ff, warn_ff;
    // pin synchronisers
    logic [2:0]  sync1_ff, sync2_ff;

    // two-stage synchronisers for asynchronous pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {mains_on_in, earth_in, phase_short_in};
            sync2_ff <= sync1_ff;
        end
    end
    wire short_s = sync2_ff[0];
    wire earth_s = sync2_ff[1];
    wire mains_s = sync2_ff[2];

    // one selection feeds both voltage monitors
    logic [9:0] uv_off, ov_off, ov_on;
    always_comb begin
        case (mains_sel_ff)
            3'h0, 3'h1: uv_off = UV_OFF_LOW;
            3'h2:       uv_off = UV_OFF_MID;
            default:    uv_off = UV_OFF_HIGH;
        endcase
        ov_off = (mains_sel_ff == 3'h4) ? OV_OFF_BRK : OV_OFF_STD;
        ov_on  = (mains_sel_ff == 3'h4) ? OV_ON_BRK : OV_ON_STD;
    end

    // speed magnitude; twice the limit is kept wider to avoid overflow
    wire [15:0] speed_mag = actual_speed[15] ? 16'(-actual_speed) : actual_speed;
    wire [16:0] speed_x2  = {max_speed_ff, 1'b0};

    // register writes; settings steer the comparators
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff      <= CTRL_RESET;
            mains_sel_ff <= MAINS_SEL_RESET;
            max_speed_ff <= MAX_SPEED_RESET;
            hs_thr_ff    <= HS_THRESH_RESET;
            mot_thr_ff   <= MOT_THRESH_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL:       ctrl_ff      <= reg_wdata[2:0];
                REG_MAINS_SEL:  mains_sel_ff <= (reg_wdata[2:0] > 3'h4) ? 3'h4 : reg_wdata[2:0];
                REG_MAX_SPEED:  max_speed_ff <= reg_wdata;
                REG_HS_THRESH:  hs_thr_ff    <= reg_wdata[7:0];
                REG_MOT_THRESH: mot_thr_ff   <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    // voltage monitors update only on the sample strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            uv_ff  <= 1'b0;
            ov_ff  <= 1'b0;
            inh_ff <= 1'b0;
        end else if (sample_en) begin
            if (dc_bus_voltage < uv_off)
                uv_ff <= 1'b1;
            else if (dc_bus_voltage > uv_off)
                uv_ff <= 1'b0;
            if (dc_bus_voltage > ov_off)
                ov_ff <= 1'b1;
            else if (dc_bus_voltage < ov_on)
                ov_ff <= 1'b0;
            inh_ff <= (dc_bus_voltage <= uv_off) || (dc_bus_voltage >= ov_off);
        end
    end

    // fault monitors: speed and current
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ospd_ff  <= 1'b0;
            short_ff <= 1'b0;
            earth_ff <= 1'b0;
        end else if (sample_en) begin
            ospd_ff  <= (speed_mag > max_speed_ff) || ({1'b0, speed_mag} > speed_x2);
            // phase short, or earth fault with mains present
            short_ff <= short_s || (earth_s && mains_s);
            earth_ff <= earth_s;
        end
    end

    // temperature comparators with hysteresis, sub-threshold clamps at zero
    wire [7:0] hs_fix_on  = HS_FIX_OFF - HS_FIX_HYST;
    wire [7:0] mot_fix_on = MOT_FIX_OFF - MOT_FIX_HYST;
    wire [7:0] hs_w_on    = (hs_thr_ff > HS_WARN_HYST) ? 8'(hs_thr_ff - HS_WARN_HYST) : 8'h00;
    wire [7:0] mot_w_on   = (mot_thr_ff > MOT_WARN_HYST) ? 8'(mot_thr_ff - MOT_WARN_HYST) : 8'h00;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hsfix_ff <= 1'b0;
            mtfix_ff <= 1'b0;
            hsw_ff   <= 1'b0;
            mtw_ff   <= 1'b0;
        end else if (sample_en) begin
            if (heatsink_temperature > HS_FIX_OFF)
                hsfix_ff <= 1'b1;
            else if (heatsink_temperature < hs_fix_on)
                hsfix_ff <= 1'b0;
            // motor fixed, clears at reclose temperature
            if (!ctrl_ff[CTRL_MOT_FIX_EN])
                mtfix_ff <= 1'b0;
            else if (motor_temperature > MOT_FIX_OFF)
                mtfix_ff <= 1'b1;
            else if (motor_temperature <= mot_fix_on)
                mtfix_ff <= 1'b0;
            // heatsink warning with 5 K drop
            if (!ctrl_ff[CTRL_HS_WARN_EN])
                hsw_ff <= 1'b0;
            else if (heatsink_temperature > hs_thr_ff)
                hsw_ff <= 1'b1;
            else if (heatsink_temperature < hs_w_on)
                hsw_ff <= 1'b0;
            // motor warning from same sensor, 15 K drop
            if (!ctrl_ff[CTRL_MOT_WARN_EN])
                mtw_ff <= 1'b0;
            else if (motor_temperature > mot_thr_ff)
                mtw_ff <= 1'b1;
            else if (motor_temperature < mot_w_on)
                mtw_ff <= 1'b0;
        end
    end

    // undervoltage history sequencer; the persistence counter counts every clock in DPM_UV_SHORT
    dpm_uv_state_t uv_st_ff;
    logic [31:0]   uv_cnt_ff;
    logic          mains_d_ff;
    wire           mains_rise = mains_s && !mains_d_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            uv_st_ff   <= DPM_UV_IDLE;
            uv_cnt_ff  <= 32'h0;
            uv_pend_ff <= 1'b0;
            hist_wr_ff <= 1'b0;
            hist_num_ff <= 12'h0;
            mains_d_ff <= 1'b0;
        end else begin
            mains_d_ff <= mains_s;
            hist_wr_ff <= 1'b0;
            case (uv_st_ff)
                DPM_UV_IDLE: begin
                    uv_cnt_ff <= 32'h0;
                    if (uv_ff) begin
                        uv_st_ff   <= DPM_UV_SHORT;
                        uv_pend_ff <= 1'b1;
                    end
                end
                DPM_UV_SHORT: begin
                    uv_cnt_ff <= uv_cnt_ff + 32'h1;
                    if (!uv_ff) begin
                        hist_wr_ff  <= 1'b1;
                        hist_num_ff <= FNUM_UV;
                        uv_pend_ff  <= 1'b0;
                        uv_st_ff    <= DPM_UV_IDLE;
                    end else if (uv_cnt_ff >= 32'(UV_PERSIST - 1) || mains_rise) begin
                        hist_wr_ff  <= 1'b1;
                        hist_num_ff <= FNUM_UV;
                        uv_st_ff    <= DPM_UV_LONG;
                    end
                end
                DPM_UV_LONG: begin
                    if (!uv_ff) begin
                        uv_pend_ff <= 1'b0;
                        uv_st_ff   <= DPM_UV_IDLE;
                    end
                end
                default: uv_st_ff <= DPM_UV_IDLE;
            endcase
        end
    end

    // history counter
    always_ff @(posedge clk) begin
        if (!rst_n)
            hist_cnt_ff <= 16'h0;
        else if (hist_wr_ff)
            hist_cnt_ff <= hist_cnt_ff + 16'h1;
    end

    // reaction summary outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trip_ff <= 1'b0;
            warn_ff <= 1'b0;
        end else begin
            trip_ff <= ospd_ff | short_ff | earth_ff | hsfix_ff | mtfix_ff;
            warn_ff <= hsw_ff | mtw_ff;
        end
    end

    // register reads, answered the next cycle
    wire [15:0] status = {5'h0, uv_pend_ff, mtw_ff, hsw_ff, mtfix_ff, hsfix_ff,
                          earth_ff, short_ff, ospd_ff, inh_ff, ov_ff, uv_ff};
    always_ff @(posedge clk) begin
        if (!rst_n)
            rdata_ff <= 16'h0;
        else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:       rdata_ff <= {13'h0, ctrl_ff};
                REG_MAINS_SEL:  rdata_ff <= {13'h0, mains_sel_ff};
                REG_MAX_SPEED:  rdata_ff <= max_speed_ff;
                REG_HS_THRESH:  rdata_ff <= {8'h0, hs_thr_ff};
                REG_MOT_THRESH: rdata_ff <= {8'h0, mot_thr_ff};
                REG_STATUS:     rdata_ff <= status;
                REG_HIST_CNT:   rdata_ff <= hist_cnt_ff;
                REG_HIST_LAST:  rdata_ff <= {4'h0, hist_num_ff};
                REG_SPEED_MAX2: rdata_ff <= speed_x2[15:0]; // one word wide, top bit dropped
                default:        rdata_ff <= 16'h0;
            endcase
        end else
            rdata_ff <= 16'h0;
    end

    assign reg_rdata         = rdata_ff;
    assign undervoltage_flag = uv_ff;
    assign overvoltage_flag  = ov_ff;
    assign pulse_inhibit     = inh_ff;
    assign trip              = trip_ff;
    assign warning           = warn_ff;
    assign hist_wr           = hist_wr_ff;
    assign hist_fault_num    = hist_num_ff;

    // checks
    a_uv_set: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && dc_bus_voltage < uv_off |=> uv_ff) else $error("undervoltage not set");
    a_uv_clear: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && dc_bus_voltage > uv_off |=> !uv_ff) else $error("undervoltage not cleared");
    a_inh_level: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && dc_bus_voltage == uv_off |=> inh_ff) else $error("no inhibit at threshold");
    a_uv_log_num: assert property (@(posedge clk) disable iff (!rst_n)
        hist_wr_ff |-> hist_num_ff == FNUM_UV) else $error("wrong history number");
    a_uv_short_log: assert property (@(posedge clk) disable iff (!rst_n)
        uv_st_ff == DPM_UV_SHORT && !uv_ff |=> hist_wr_ff) else $error("short dip not logged");
    a_uv_return_nolog: assert property (@(posedge clk) disable iff (!rst_n)
        uv_st_ff == DPM_UV_LONG && !uv_ff |=> !hist_wr_ff && !uv_pend_ff) else $error("return logged");
    a_ospd_mag: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && speed_mag > max_speed_ff |=> ospd_ff ##1 trip_ff) else $error("overspeed missed");
    a_earth_trip: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && earth_s |=> earth_ff) else $error("earth fault missed");
    a_hs_fix: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && heatsink_temperature > HS_FIX_OFF |=> hsfix_ff) else $error("heatsink trip missed");
    a_mot_off: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && !ctrl_ff[CTRL_MOT_FIX_EN] |=> !mtfix_ff) else $error("motor off ignored");
    a_hold_flags: assert property (@(posedge clk) disable iff (!rst_n)
        !sample_en |=> $stable(uv_ff) && $stable(hsfix_ff)) else $error("flag moved off sample");
    a_short_mains: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && earth_s && mains_s |=> short_ff)
        else $error("earth at mains not shown as short");
    a_mot_reclose: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && motor_temperature <= mot_fix_on |=> !mtfix_ff)
        else $error("motor fixed not reclosed");
    a_hs_warn_off: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en && !ctrl_ff[CTRL_HS_WARN_EN] |=> !hsw_ff)
        else $error("heatsink warning while off");
    a_mains_log: assert property (@(posedge clk) disable iff (!rst_n)
        uv_st_ff == DPM_UV_SHORT && uv_ff && mains_rise |=> hist_wr_ff)
        else $error("mains connect not logged");
    c_uv_short: cover property (@(posedge clk) disable iff (!rst_n) uv_st_ff == DPM_UV_SHORT && !uv_ff);
    c_uv_long: cover property (@(posedge clk) disable iff (!rst_n) uv_st_ff == DPM_UV_LONG);
    c_trip: cover property (@(posedge clk) disable iff (!rst_n) trip_ff);
    c_warn: cover property (@(posedge clk) disable iff (!rst_n) warn_ff);
endmodule // dpm_monitors

// ==== logic/dpm_pkg.sv ====
// constants and types shared by the drive protection monitors
package dpm_pkg;
    // register indices (word addresses on the plain register port)
    localparam logic [3:0] REG_CTRL       = 4'h0;
    localparam logic [3:0] REG_MAINS_SEL  = 4'h1;
    localparam logic [3:0] REG_MAX_SPEED  = 4'h2;
    localparam logic [3:0] REG_HS_THRESH  = 4'h3;
    localparam logic [3:0] REG_MOT_THRESH = 4'h4;
    localparam logic [3:0] REG_STATUS     = 4'h5;
    localparam logic [3:0] REG_HIST_CNT   = 4'h6;
    localparam logic [3:0] REG_HIST_LAST  = 4'h7;
    localparam logic [3:0] REG_SPEED_MAX2 = 4'h8;
    // control register fields
    localparam int CTRL_MOT_FIX_EN   = 0;
    localparam int CTRL_HS_WARN_EN   = 1;
    localparam int CTRL_MOT_WARN_EN  = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    // status register fields
    localparam int ST_UV    = 0;
    localparam int ST_OV    = 1;
    localparam int ST_INH   = 2;
    localparam int ST_OSPD  = 3;
    localparam int ST_SHORT = 4;
    localparam int ST_EARTH = 5;
    localparam int ST_HSFIX = 6;
    localparam int ST_MTFIX = 7;
    localparam int ST_HSW   = 8;
    localparam int ST_MTW   = 9;
    localparam int ST_UVPND = 10;
    // voltage thresholds in volts, 10 bits
    localparam logic [9:0] UV_OFF_LOW  = 10'h11d; // 285 V
    localparam logic [9:0] UV_OFF_MID  = 10'h148; // 328 V
    localparam logic [9:0] UV_OFF_HIGH = 10'h156; // 342 V
    localparam logic [9:0] OV_OFF_STD  = 10'h302; // 770 V
    localparam logic [9:0] OV_ON_STD   = 10'h2f3; // 755 V
    localparam logic [9:0] OV_OFF_BRK  = 10'h320; // 800 V
    localparam logic [9:0] OV_ON_BRK   = 10'h311; // 785 V
    localparam logic [2:0] MAINS_SEL_RESET = 3'h1;
    // temperatures in whole degrees C, 8 bits
    localparam logic [7:0] HS_FIX_OFF   = 8'h55; // 85 C
    localparam logic [7:0] HS_FIX_HYST  = 8'h05; // 5 K
    localparam logic [7:0] MOT_FIX_OFF  = 8'h96; // 150 C
    localparam logic [7:0] MOT_FIX_HYST = 8'h0f; // 15 K
    localparam logic [7:0] HS_WARN_HYST = 8'h05;
    localparam logic [7:0] MOT_WARN_HYST = 8'h0f;
    localparam logic [7:0] HS_THRESH_RESET  = 8'h50;
    localparam logic [7:0] MOT_THRESH_RESET = 8'h82;
    // speed
    localparam logic [15:0] MAX_SPEED_RESET = 16'h0bb8;
    // fault numbers
    localparam logic [11:0] FNUM_UV    = 12'd1030;
    localparam logic [11:0] FNUM_OV    = 12'd1020;
    localparam logic [11:0] FNUM_OSPD  = 12'd200;
    localparam logic [11:0] FNUM_SHORT = 12'd11;
    localparam logic [11:0] FNUM_EARTH = 12'd12;
    localparam logic [11:0] FNUM_HSFIX = 12'd50;
    localparam logic [11:0] FNUM_MTFIX = 12'd53;
    localparam logic [11:0] FNUM_HSW   = 12'd2054;
    localparam logic [11:0] FNUM_MTW   = 12'd2057;
    // timing: undervoltage persistence before history entry
    localparam longint CLK_HZ       = 20000000;
    localparam longint UV_PERSIST_S = 3;
    localparam longint UV_PERSIST_CYC = UV_PERSIST_S * CLK_HZ;
    // undervoltage history sequencer
    typedef enum logic [2:0] {
        DPM_UV_IDLE = 3'b001,
        DPM_UV_SHORT = 3'b010,
        DPM_UV_LONG = 3'b100
    } dpm_uv_state_t;
endpackage : dpm_pkg

// ==== testbench/dpm_plant_model.sv ====
// plant-side model: measurements, sampling strobe and fault history log
module dpm_plant_model (
    input  wire logic        clk,                  // system clock
    input  wire logic        rst_n,                // sync reset, active low
    input  wire logic [9:0]  cmd_volt,             // dc bus to present
    input  wire logic [15:0] cmd_speed,            // speed to present
    input  wire logic [7:0]  cmd_hs,               // heatsink temp to present
    input  wire logic [7:0]  cmd_mot,              // motor temp to present
    input  wire logic        hist_wr,              // history write pulse
    input  wire logic [11:0] hist_fault_num,       // number with the pulse
    output logic             sample_en,            // sampling strobe
    output logic      [9:0]  dc_bus_voltage,       // measured dc bus
    output logic      [15:0] actual_speed,         // measured speed
    output logic      [7:0]  heatsink_temperature, // measured heatsink
    output logic      [7:0]  motor_temperature,    // measured motor
    output logic      [7:0]  entries,              // entries logged
    output logic      [11:0] last_num              // last number logged
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_ff;
    // strobe every fourth clock, so flags must hold between samples
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_ff    <= 2'h0;
            sample_en <= 1'b0;
        end else begin
            div_ff    <= div_ff + 2'h1;
            sample_en <= (div_ff == 2'h3);
        end
    end
    // converters lag the command by one clock
    always_ff @(posedge clk) begin
        dc_bus_voltage       <= cmd_volt;
        actual_speed         <= cmd_speed;
        heatsink_temperature <= cmd_hs;
        motor_temperature    <= cmd_mot;
    end
    // history log kept by the reaction side
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            entries  <= 8'h0;
            last_num <= 12'h0;
        end else if (hist_wr) begin
            entries  <= entries + 8'h1;
            last_num <= hist_fault_num;
        end
    end
endmodule // dpm_plant_model

// ==== testbench/drive_protection_monitors_tb_top.sv ====
// self-checking bench for the drive protection monitors
module drive_protection_monitors_tb_top
    import dpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int UVP = 50; // short persistence keeps the run brief
    typedef struct packed {logic [2:0] sel; logic [9:0] v; logic [2:0] f;} dpm_vrow_t;
    typedef struct packed {logic [2:0] c; logic m; logic [7:0] t; logic [3:0] b; logic [2:0] f;} dpm_trow_t;
    logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, psh = 1'b0, ear = 1'b0, mon = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0, spd = 16'h0, rv, reg_rdata, act_spd;
    logic [9:0]  volt = 10'h1f4, vbus;
    logic [7:0]  hs = 8'h19, mt = 8'h19, hs_m, mt_m, ents, e0;
    logic [11:0] hnum, lnum;
    logic        smp, uv, ov, inh, trip, warn, hwr;
    int          fail_count = 0, n_tests = 0;
    logic [3:0]  ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hf};
    logic [15:0] rx [8] = '{16'h1, 16'h1, 16'h0bb8, 16'h50, 16'h82, 16'h0, 16'h1770, 16'h0};
    logic [15:0] sv [4] = '{16'hfc17, 16'h03e8, 16'h03e9, 16'hfc18};
    logic [2:0]  pin [4] = '{3'h2, 3'h3, 3'h4, 3'h0};
    logic [2:0]  pex [4] = '{3'h5, 3'h7, 3'h3, 3'h0};
    // rows: selection, dc bus, expected {uv, ov, inhibit}
    dpm_vrow_t vr [11] = '{'{3'h0, 10'h11c, 3'h5}, '{3'h0, 10'h11e, 3'h0}, '{3'h1, 10'h11c, 3'h5},
        '{3'h2, 10'h147, 3'h5}, '{3'h2, 10'h149, 3'h0}, '{3'h3, 10'h155, 3'h5}, '{3'h3, 10'h157, 3'h0},
        '{3'h4, 10'h155, 3'h5}, '{3'h4, 10'h316, 3'h0}, '{3'h3, 10'h316, 3'h3}, '{3'h1, 10'h1f4, 3'h0}};
    // rows: ctrl, motor side, temp, status bit, expected {bit, trip, warning}
    dpm_trow_t tr [14] = '{'{3'h1, 1'b0, 8'h56, 4'h6, 3'h6}, '{3'h1, 1'b0, 8'h51, 4'h6, 3'h6},
        '{3'h1, 1'b0, 8'h4f, 4'h6, 3'h0}, '{3'h1, 1'b1, 8'h97, 4'h7, 3'h6}, '{3'h1, 1'b1, 8'h88, 4'h7, 3'h6},
        '{3'h1, 1'b1, 8'h87, 4'h7, 3'h0}, '{3'h0, 1'b1, 8'h97, 4'h7, 3'h0}, '{3'h7, 1'b0, 8'h51, 4'h8, 3'h5},
        '{3'h7, 1'b0, 8'h4c, 4'h8, 3'h5}, '{3'h7, 1'b0, 8'h4a, 4'h8, 3'h0}, '{3'h7, 1'b1, 8'h83, 4'h9, 3'h5},
        '{3'h7, 1'b1, 8'h74, 4'h9, 3'h5}, '{3'h7, 1'b1, 8'h72, 4'h9, 3'h0}, '{3'h1, 1'b1, 8'h83, 4'h9, 3'h0}};

    dpm_monitors #(.UV_PERSIST(UVP)) dut (.clk(clk), .rst_n(rst_n), .sample_en(smp), .dc_bus_voltage(vbus),
        .actual_speed(act_spd), .heatsink_temperature(hs_m), .motor_temperature(mt_m), .phase_short_in(psh),
        .earth_in(ear), .mains_on_in(mon), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .undervoltage_flag(uv), .overvoltage_flag(ov),
        .pulse_inhibit(inh), .trip(trip), .warning(warn), .hist_wr(hwr), .hist_fault_num(hnum));
    dpm_plant_model plant (.clk(clk), .rst_n(rst_n), .cmd_volt(volt), .cmd_speed(spd), .cmd_hs(hs),
        .cmd_mot(mt), .hist_wr(hwr), .hist_fault_num(hnum), .sample_en(smp), .dc_bus_voltage(vbus),
        .actual_speed(act_spd), .heatsink_temperature(hs_m), .motor_temperature(mt_m), .entries(ents),
        .last_num(lnum));

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // two full samples, then room for the delayed trip and warning
    task automatic settle();
        int seen = 0;
        for (int i = 0; i < 40 && seen < 2; i++) begin
            @(posedge clk);
            if (smp === 1'b1) seen++;
        end
        if (seen < 2) begin
            fail_count++;
            $display("BAD sample strobe expected 2 seen %0d", seen);
            print_verdict();
        end
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], rv);
            chk("reset register", rx[i], rv); // reset values
        end
        chk("reset outputs", 16'h0, {10'h0, uv, ov, inh, trip, warn, hwr}); // idle flags
        $display("test reset done");
        foreach (vr[i]) begin
            wr(REG_MAINS_SEL, {13'h0, vr[i].sel}); // same selection on all units
            volt <= vr[i].v;
            settle();
            chk("voltage row", {13'h0, vr[i].f}, {13'h0, uv, ov, inh});
        end
        foreach (tr[i]) begin
            wr(REG_CTRL, {13'h0, tr[i].c});
            hs <= tr[i].m ? 8'h19 : tr[i].t;
            mt <= tr[i].m ? tr[i].t : 8'h19;
            settle();
            rd(REG_STATUS, rv);
            chk("temp row", {13'h0, tr[i].f}, {13'h0, rv[tr[i].b], trip, warn});
        end
        $display("test tables done");
        wr(REG_MAINS_SEL, 16'h0);
        volt <= 10'h11d;
        settle();
        chk("inhibit at threshold", 16'h1, {15'h0, inh});
        wr(REG_MAX_SPEED, 16'h03e8);
        volt <= 10'h1f4;
        rd(REG_SPEED_MAX2, rv);
        chk("twice max speed", 16'h07d0, rv);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            spd <= sv[i];
            settle();
            rd(REG_STATUS, rv);
            chk("overspeed", {14'h0, ~i[0], ~i[0]}, {14'h0, rv[ST_OSPD], trip});
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {psh, ear, mon} <= pin[i];
            settle();
            rd(REG_STATUS, rv);
            chk("short and earth", {13'h0, pex[i]}, {13'h0, rv[ST_EARTH], rv[ST_SHORT], trip});
        end
        $display("test speed and current done");
        // brief dip, then return: logged once with the fixed number
        e0 = ents;
        @(posedge clk);
        volt <= 10'h0c8;
        settle();
        rd(REG_STATUS, rv);
        chk("pending", 16'h1, {15'h0, rv[ST_UVPND]});
        @(posedge clk);
        volt <= 10'h1f4;
        settle();
        chk("dip entry", {8'h0, e0 + 8'h1}, {8'h0, ents});
        chk("fault number", 16'h0406, {4'h0, lnum});
        // long undervoltage logs once, clearing logs nothing
        e0 = ents;
        @(posedge clk);
        volt <= 10'h0c8;
        repeat (UVP + 20) @(posedge clk);
        #1 chk("long entry", {8'h0, e0 + 8'h1}, {8'h0, ents});
        @(posedge clk);
        volt <= 10'h1f4;
        settle();
        chk("no entry on clear", {8'h0, e0 + 8'h1}, {8'h0, ents});
        // mains arriving during undervoltage logs at once
        e0 = ents;
        @(posedge clk);
        volt <= 10'h0c8;
        settle();
        @(posedge clk);
        mon <= 1'b1;
        settle();
        chk("mains entry", {8'h0, e0 + 8'h1}, {8'h0, ents});
        @(posedge clk);
        volt <= 10'h1f4;
        settle();
        chk("mains return", {8'h0, e0 + 8'h1}, {8'h0, ents});
        rd(REG_STATUS, rv);
        chk("pending deleted", 16'h0, {15'h0, rv[ST_UVPND]});
        rd(REG_HIST_LAST, rv);
        chk("history last", 16'h0406, rv);
        rd(REG_HIST_CNT, rv);
        chk("history count", {8'h0, ents}, rv);
        $display("test history done");
        // reset in mid-run while undervoltage is shown
        @(posedge clk);
        {mon, volt} <= {1'b0, 10'h0c8};
        settle();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("flags in reset", 16'h0, {13'h0, uv, inh, hwr}); // cleared state
        @(posedge clk);
        {rst_n, volt} <= {1'b1, 10'h1f4};
        rd(REG_MAINS_SEL, rv);
        chk("selection after reset", 16'h1, rv); // reset selection
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule // drive_protection_monitors_tb_top
